// >>> common/swc_pkg.sv
// Constants for the sleep and wake configuration block
// Overview of operation
// - With trap select clear, writing sleep request one starts sleep of chosen type
// - With trap select set, sleep request write raises management interrupt, no sleep
// - Each sleep request write sets trap flag; flag drives management interrupt only if trap select
// - Wake source select clear: wake flag sets only on power-on output falling edge
// - Wake source select set: wake flag sets on enabled wake events and that edge
// - Configuration bit 7 powers the low-frequency clock loop; reset leaves it off
`default_nettype none
package swc_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_CFG = 8'hF0;
    // Configuration register fields
    localparam int CFG_TRAP_BIT = 0;
    localparam int CFG_WSRC_BIT = 1;
    localparam int CFG_LOOP_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WMASK = 8'h83;
    // Control register fields
    localparam int CTRL_REQ_BIT = 0;
    localparam int TYPE_LSB = 1;
    localparam int TYPE_W = 3;
    localparam logic [TYPE_W-1:0] TYPE_RESET = 3'h0;
    // Status and mask layout
    localparam int ST_W = 2;
    localparam int ST_TRAP_BIT = 0;
    localparam int ST_WAKE_BIT = 1;
    localparam logic [ST_W-1:0] ST_RESET = 2'h0;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : swc_pkg
`default_nettype wire

// >>> design/swc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module swc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous input and synchronised output
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : swc_sync
`default_nettype wire

// >>> design/swc_top.sv
// Sleep and wake configuration block with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module swc_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [swc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [swc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [swc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [swc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Wake sources and infrared loop running status, from pins
    input wire logic power_on_out_n,
    input wire logic wake_event_in,
    input wire logic ir_loop_running_in,
    // Sleep sequencer and management interrupt
    output logic sleep_start,
    output logic [swc_pkg::TYPE_W-1:0] sleep_type_field,
    output logic smi_out,
    // Infrared clock loop
    output logic ir_clock_loop_power,
    output logic ir_timebase_sel,
    // Interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Sticky flag update: a set in the same cycle as a clear wins
    function automatic logic [swc_pkg::ST_W-1:0] sticky(
        input logic [swc_pkg::ST_W-1:0] cur,
        input logic [swc_pkg::ST_W-1:0] set,
        input logic [swc_pkg::ST_W-1:0] clr
    );
        sticky = (cur & ~clr) | set;
    endfunction : sticky

    // Register storage
    logic aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
    logic [swc_pkg::ADDR_W-1:0] awaddr_reg;
    logic [swc_pkg::DATA_W-1:0] wdata_reg, rdata_reg;
    logic wstrb0_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [7:0] cfg_reg;
    logic [swc_pkg::TYPE_W-1:0] type_reg;
    logic [swc_pkg::ST_W-1:0] status_reg, mask_reg, status_next;
    logic start_reg, pon_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs pass two flip-flops; power-on rests high so reset makes no edge
    logic pon_sync, wake_sync, loop_sync;
    swc_sync #(.W(1), .RST_VAL(1'b1)) u_pon_sync (
        .aclk(aclk), .aresetn(aresetn), .async_in(power_on_out_n), .sync_out(pon_sync)
    );
    swc_sync #(.W(2), .RST_VAL(2'b00)) u_wake_sync (
        .aclk(aclk), .aresetn(aresetn),
        .async_in({ir_loop_running_in, wake_event_in}), .sync_out({loop_sync, wake_sync})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write decode: a write commits once both address and data are held
    wire wr_fire = aw_have_reg && w_have_reg;
    wire wr_ctrl = wr_fire && wstrb0_reg && (awaddr_reg == swc_pkg::ADDR_CTRL);
    wire wr_status = wr_fire && wstrb0_reg && (awaddr_reg == swc_pkg::ADDR_STATUS);
    wire wr_mask = wr_fire && wstrb0_reg && (awaddr_reg == swc_pkg::ADDR_MASK);
    wire wr_cfg = wr_fire && wstrb0_reg && (awaddr_reg == swc_pkg::ADDR_CFG);
    wire wr_known = (awaddr_reg == swc_pkg::ADDR_CTRL) || (awaddr_reg == swc_pkg::ADDR_STATUS)
        || (awaddr_reg == swc_pkg::ADDR_MASK) || (awaddr_reg == swc_pkg::ADDR_CFG);
    wire trap_sel = cfg_reg[swc_pkg::CFG_TRAP_BIT];
    wire wsrc_sel = cfg_reg[swc_pkg::CFG_WSRC_BIT];
    wire req_write = wr_ctrl && wdata_reg[swc_pkg::CTRL_REQ_BIT];

    // Event sources for the two sticky flags
    wire pon_fall = pon_prev_reg && !pon_sync;
    wire wake_set = pon_fall || (wsrc_sel && wake_sync);
    wire [swc_pkg::ST_W-1:0] st_set = {wake_set, req_write};
    wire [swc_pkg::ST_W-1:0] st_clr = wr_status ? wdata_reg[swc_pkg::ST_W-1:0] : '0;
    assign status_next = sticky(status_reg, st_set, st_clr);

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; reserved configuration bits read as zero
    wire [swc_pkg::ADDR_W-1:0] ar = s_axi_araddr;
    wire rd_known = (ar == swc_pkg::ADDR_CTRL) || (ar == swc_pkg::ADDR_STATUS)
        || (ar == swc_pkg::ADDR_MASK) || (ar == swc_pkg::ADDR_CFG);
    wire [swc_pkg::DATA_W-1:0] rd_mux =
        (ar == swc_pkg::ADDR_CTRL) ? {28'h000_0000, type_reg, 1'b0} :
        (ar == swc_pkg::ADDR_STATUS) ? {30'h0000_0000, status_reg} :
        (ar == swc_pkg::ADDR_MASK) ? {30'h0000_0000, mask_reg} :
        (ar == swc_pkg::ADDR_CFG) ? {24'h00_0000, cfg_reg & swc_pkg::CFG_WMASK} :
        swc_pkg::DATA_ZERO;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: one write under way; response follows both halves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= swc_pkg::DATA_ZERO;
            wstrb0_reg <= 1'b0;
            bresp_reg <= swc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read channel: data registered on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= swc_pkg::DATA_ZERO;
            rresp_reg <= swc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_known ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Configuration, control, mask and flags; reserved bits are not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= swc_pkg::CFG_RESET;
            type_reg <= swc_pkg::TYPE_RESET;
            mask_reg <= swc_pkg::ST_RESET;
            status_reg <= swc_pkg::ST_RESET;
            start_reg <= 1'b0;
            pon_prev_reg <= 1'b1;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= wdata_reg[7:0] & swc_pkg::CFG_WMASK;
            end
            if (wr_ctrl) begin
                type_reg <= wdata_reg[swc_pkg::TYPE_LSB +: swc_pkg::TYPE_W];
            end
            if (wr_mask) begin
                mask_reg <= wdata_reg[swc_pkg::ST_W-1:0];
            end
            status_reg <= status_next;
            start_reg <= req_write && !trap_sel;
            pon_prev_reg <= pon_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready = !w_have_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign sleep_start = start_reg;
    assign sleep_type_field = type_reg;
    // Trap flag reaches the management interrupt only when trapping is chosen
    assign smi_out = status_reg[swc_pkg::ST_TRAP_BIT] && trap_sel;
    assign ir_clock_loop_power = cfg_reg[swc_pkg::CFG_LOOP_BIT];
    // Loop output is only trusted once powered and reporting it runs
    assign ir_timebase_sel = ir_clock_loop_power && loop_sync;
    assign irq = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_req_untrapped;
        req_write && !trap_sel;
    endsequence
    sequence s_req_trapped;
        req_write && trap_sel && !wr_cfg;
    endsequence
    sequence s_start_pulse;
        sleep_start ##1 !sleep_start;
    endsequence

    a_sleep_start_pulse: assert property (s_req_untrapped |=> s_start_pulse)
        else $error("sleep start not a single pulse after request");
    a_trap_no_sleep: assert property (s_req_trapped |=> !sleep_start && smi_out)
        else $error("trapped request started sleep or missed interrupt");
    a_trap_flag_set: assert property (req_write |=> status_reg[swc_pkg::ST_TRAP_BIT])
        else $error("trap flag not set by sleep request");
    a_smi_gated: assert property (!trap_sel |-> !smi_out)
        else $error("interrupt raised while trap select clear");
    a_wake_on_fall: assert property (pon_prev_reg && !pon_sync
        |=> status_reg[swc_pkg::ST_WAKE_BIT])
        else $error("wake flag missed power-on falling edge");
    a_wake_cause: assert property ($rose(status_reg[swc_pkg::ST_WAKE_BIT])
        |-> $past(pon_fall) || ($past(wsrc_sel) && $past(wake_sync)))
        else $error("wake flag set without a permitted cause");
    a_wake_event: assert property (wsrc_sel && wake_sync
        |=> status_reg[swc_pkg::ST_WAKE_BIT])
        else $error("enabled wake event did not set wake flag");
    a_loop_power: assert property (wr_cfg |=> ir_clock_loop_power
        == $past(wdata_reg[swc_pkg::CFG_LOOP_BIT]))
        else $error("loop power does not follow bit 7");
    a_ir_timebase: assert property (ir_timebase_sel |-> ir_clock_loop_power)
        else $error("unpowered loop selected as time base");
    a_cfg_reserved: assert property (s_axi_rvalid |-> !(s_axi_rresp == swc_pkg::RESP_OKAY
        && $past(s_axi_araddr) == swc_pkg::ADDR_CFG && $past(s_axi_arready)
        && (|s_axi_rdata[6:2])))
        else $error("reserved configuration bits read nonzero");
endmodule : swc_top
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the sleep and wake configuration block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic aclk, aresetn, awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
    logic pwr_n, wake_ev, loop_run, sleep_start, smi, loop_pwr, tb_sel, irq;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, got;
    logic [1:0] br, rr, resp;
    logic [2:0] styp;
    logic [3:0] ws;
    int failures = 0;
    int total_checks = 0;
    int pulses = 0;
    ////////////////////////////////////////////////////////////////////////
    swc_top i_swc_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .power_on_out_n(pwr_n), .wake_event_in(wake_ev), .ir_loop_running_in(loop_run),
        .sleep_start(sleep_start), .sleep_type_field(styp), .smi_out(smi),
        .ir_clock_loop_power(loop_pwr), .ir_timebase_sel(tb_sel), .irq(irq));
    // Clock at 100 MHz
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Sleep start pulses are counted, so their exact cycle need not be guessed
    always @(posedge aclk) begin
        if (sleep_start === 1'b1) pulses <= pulses + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s: saw %h, expected %h", $time, what, seen, exp);
        end
    endtask : check
    // Both halves offered together; bready and rready stay high all run
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!done && n < 50) begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv === 1'b1) begin
                resp = br;
                done = 1'b1;
            end
            n++;
        end
        if (!done) check(32'h0000_0001, 32'h0000_0000, "write hang");
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        ara <= a;
        arv <= 1'b1;
        while (!done && n < 50) begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'b0;
            if (rv === 1'b1) begin
                got = rd;
                resp = rr;
                done = 1'b1;
            end
            n++;
        end
        if (!done) check(32'h0000_0001, 32'h0000_0000, "read hang");
    endtask : axi_read
    task automatic idle(input int c);
        repeat (c) @(posedge aclk);
    endtask : idle
    task automatic final_report;
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the tests need well under two hundred cycles
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        final_report();
    end
    initial begin
        {awv, wv, arv, wake_ev, loop_run} = '0;
        {brdy, rrdy} = 2'h3;
        {awa, ara, wd} = '0;
        ws = 4'hF;
        pwr_n = 1'b1;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and stored bits of the configuration register
        axi_read(swc_pkg::ADDR_CFG);
        check(got, 32'h0000_0000, "cfg reset");
        check({31'h0, loop_pwr}, 32'h0000_0000, "loop power at reset");
        loop_run <= 1'b1;
        axi_write(swc_pkg::ADDR_CFG, 32'h0000_00FC);
        check({30'h0, resp}, 32'h0000_0000, "cfg write okay");
        axi_read(swc_pkg::ADDR_CFG);
        check(got, 32'h0000_0080, "reserved bits dropped");
        check({30'h0, resp}, 32'h0000_0000, "cfg read okay");
        // Lane 0 disabled or an unmapped address must leave the register alone
        ws <= 4'hE;
        axi_write(swc_pkg::ADDR_CFG, 32'h0000_0003);
        ws <= 4'hF;
        axi_write(8'h10, 32'h0000_0001);
        check({30'h0, resp}, 32'h0000_0002, "unmapped write");
        axi_read(swc_pkg::ADDR_CFG);
        check(got, 32'h0000_0080, "masked write ignored");
        idle(4);
        check({30'h0, loop_pwr, tb_sel}, 32'h0000_0003, "loop runs");
        loop_run <= 1'b0;
        idle(3);
        check({30'h0, loop_pwr, tb_sel}, 32'h0000_0002, "loop not running");
        axi_read(8'h10);
        check({30'h0, resp}, 32'h0000_0002, "unmapped read");
        $display("test config done");
        // Sleep request with trap select clear, then set
        axi_write(swc_pkg::ADDR_CFG, 32'h0000_0000);
        check({30'h0, loop_pwr, tb_sel}, 32'h0000_0000, "loop off");
        axi_write(swc_pkg::ADDR_CTRL, 32'h0000_000B);
        idle(3);
        check(pulses, 1, "sleep started");
        check({29'h0, styp}, 32'h0000_0005, "sleep type");
        check({31'h0, smi}, 32'h0000_0000, "no smi");
        axi_read(swc_pkg::ADDR_STATUS);
        check(got, 32'h0000_0001, "trap flag always set");
        axi_write(swc_pkg::ADDR_STATUS, 32'h0000_0001);
        axi_write(swc_pkg::ADDR_CFG, 32'h0000_0001);
        axi_write(swc_pkg::ADDR_CTRL, 32'h0000_0003);
        idle(3);
        check(pulses, 1, "trapped, no sleep");
        check({31'h0, smi}, 32'h0000_0001, "smi raised");
        axi_write(swc_pkg::ADDR_MASK, 32'h0000_0001);
        idle(1);
        check({31'h0, irq}, 32'h0000_0001, "irq unmasked");
        axi_write(swc_pkg::ADDR_STATUS, 32'h0000_0001);
        idle(1);
        check({30'h0, smi, irq}, 32'h0000_0000, "flag cleared");
        $display("test sleep done");
        // Wake flag sources
        axi_write(swc_pkg::ADDR_CFG, 32'h0000_0000);
        wake_ev <= 1'b1;
        idle(6);
        wake_ev <= 1'b0;
        idle(6);
        axi_read(swc_pkg::ADDR_STATUS);
        check(got, 32'h0000_0000, "event ignored");
        pwr_n <= 1'b0;
        idle(8);
        axi_read(swc_pkg::ADDR_STATUS);
        check(got, 32'h0000_0002, "power-on edge");
        pwr_n <= 1'b1;
        axi_write(swc_pkg::ADDR_STATUS, 32'h0000_0002);
        axi_write(swc_pkg::ADDR_CFG, 32'h0000_0002);
        wake_ev <= 1'b1;
        idle(6);
        wake_ev <= 1'b0;
        idle(6);
        axi_read(swc_pkg::ADDR_STATUS);
        check(got, 32'h0000_0002, "event wakes");
        axi_write(swc_pkg::ADDR_STATUS, 32'h0000_0002);
        pwr_n <= 1'b0;
        idle(8);
        axi_read(swc_pkg::ADDR_STATUS);
        check(got, 32'h0000_0002, "edge still wakes");
        $display("test wake done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
